/* src/pmc_pkg.sv */
package pmc_pkg;
   localparam logic [7:0] PWR_CTRL_ADDR = 8'h87;
   localparam logic [7:0] ANA_DIS_ADDR = 8'h88;
   localparam logic [7:0] MODE_ADDR = 8'h89;
   localparam int IDLE_BIT = 0;
   localparam int STOP_BIT = 1;
   localparam int GF_LSB = 2;
   localparam int GF_MSB = 6;
   localparam int BAUD_BIT = 7;
   localparam logic [7:0] PWR_CTRL_RST = 8'h00;
   localparam logic [7:0] ANA_DIS_RST = 8'h00;
   localparam logic [15:0] RESET_VECTOR = 16'h0000;
   localparam int RST_SEQ_CYCLES = 4;
   typedef enum logic [3:0] {
      PMC_RUN = 4'b0001,
      PMC_PEND = 4'b0010,
      PMC_IDLE = 4'b0100,
      PMC_STOP = 4'b1000
   } pmc_state_t;
endpackage : pmc_pkg

/* src/pmc_power_mode.sv */
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module pmc_power_mode (
   input wire logic sys_clk, // 50 mhz system clock
   input wire logic reset, // synchronous, active high
   input wire logic [7:0] reg_addr, // register address
   input wire logic [7:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [7:0] reg_rdata, // read data, cycle after read strobe
   input wire logic instr_done, // cpu finished current instruction
   input wire logic [7:0] irq_req, // interrupt requests
   input wire logic [7:0] irq_en, // interrupt enables
   input wire logic wdt_en, // watchdog_unit enabled
   input wire logic wdt_expire, // watchdog_unit expiry pulse
   input wire logic mcd_en, // missing-clock detector enabled
   input wire logic mcd_fault, // missing-clock detector timeout
   input wire logic osc_off, // active oscillator switched off
   input wire logic ext_reset_n, // external reset pin, active low
   output logic cpu_clk_en, // cpu clock enable
   output logic periph_clk_en, // peripheral and timer clock enable
   output logic sys_clk_run, // system oscillator run
   output logic wake_irq, // one-cycle pulse: interrupt wake
   output logic int_reset, // device reset request
   output logic [15:0] fetch_addr, // fetch address after reset
   output logic [7:0] analog_dis, // per analog peripheral disable
   output logic [1:0] mode_state // 01 idle, 10 stop
);
   pmc_pkg::pmc_state_t state_q, state_d;
   logic [7:0] pwr_q;
   logic [7:0] ana_q;
   logic [7:0] rdata_q;
   logic [2:0] rst_sync_q;
   logic ext_rst_q;
   logic [2:0] seq_q;
   logic pend_idle_q, pend_stop_q;
   logic wake_q;
   logic [15:0] fetch_q;

   // external reset pin resynchronised; counts once stages two and three agree
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rst_sync_q <= 3'h0;
         ext_rst_q <= 1'b0;
      end else begin
         rst_sync_q <= {rst_sync_q[1:0], ~ext_reset_n};
         if (rst_sync_q[1] == rst_sync_q[2]) begin
            ext_rst_q <= rst_sync_q[2];
         end
      end
   end

   wire wr_pwr = reg_wr && (reg_addr == pmc_pkg::PWR_CTRL_ADDR);
   wire wr_ana = reg_wr && (reg_addr == pmc_pkg::ANA_DIS_ADDR);
   wire in_idle = (state_q == pmc_pkg::PMC_IDLE);
   wire in_stop = (state_q == pmc_pkg::PMC_STOP);
   wire irq_wake = |(irq_req & irq_en);
   wire wdt_rst = wdt_en && wdt_expire && !in_stop;
   wire mcd_rst = mcd_en && mcd_fault && in_stop;
   wire osc_rst = osc_off && !in_stop;
   wire any_rst = ext_rst_q || wdt_rst || mcd_rst || osc_rst;
   wire seq_busy = (seq_q != 3'h0);

   // state machine for the two modes
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         pmc_pkg::PMC_RUN: begin
            if (pend_idle_q || pend_stop_q) begin
               state_d = pmc_pkg::PMC_PEND;
            end
         end
         pmc_pkg::PMC_PEND: begin
            if (instr_done) begin
               state_d = pend_stop_q ? pmc_pkg::PMC_STOP : pmc_pkg::PMC_IDLE;
            end
         end
         pmc_pkg::PMC_IDLE: begin
            if (irq_wake) begin
               state_d = pmc_pkg::PMC_RUN;
            end
         end
         pmc_pkg::PMC_STOP: state_d = pmc_pkg::PMC_STOP;
      endcase
      if (any_rst) begin
         state_d = pmc_pkg::PMC_RUN;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_q <= pmc_pkg::PMC_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // select bits cleared by any reset
   always_ff @(posedge sys_clk) begin
      if (reset || any_rst) begin
         pwr_q <= pmc_pkg::PWR_CTRL_RST;
         pend_idle_q <= 1'b0;
         pend_stop_q <= 1'b0;
      end else begin
         if (wr_pwr) begin
            pwr_q <= reg_wdata;
            pend_idle_q <= reg_wdata[pmc_pkg::IDLE_BIT];
            pend_stop_q <= reg_wdata[pmc_pkg::STOP_BIT];
         end else if (in_idle && irq_wake) begin
            pwr_q[pmc_pkg::IDLE_BIT] <= 1'b0;
            pend_idle_q <= 1'b0;
         end else if (state_q == pmc_pkg::PMC_PEND && instr_done) begin
            pend_idle_q <= 1'b0;
            pend_stop_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ana_q <= pmc_pkg::ANA_DIS_RST;
      end else if (wr_ana) begin
         ana_q <= reg_wdata;
      end
   end

   // reset sequence then fetch from reset vector
   always_ff @(posedge sys_clk) begin
      if (reset || any_rst) begin
         seq_q <= 3'(pmc_pkg::RST_SEQ_CYCLES);
         fetch_q <= pmc_pkg::RESET_VECTOR;
      end else if (seq_busy) begin
         seq_q <= seq_q - 3'h1;
      end
   end

   // wake pulse lets core service the interrupt, then resume
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= in_idle && irq_wake && !any_rst;
      end
   end

   // idle bit reads zero; stop bit likewise
   wire [7:0] pwr_view = {pwr_q[7:2], 2'b00};
   wire [7:0] mode_view = {6'h00, in_stop, in_idle};
   wire [7:0] rd_mux = (reg_addr == pmc_pkg::PWR_CTRL_ADDR) ? pwr_view :
                       (reg_addr == pmc_pkg::ANA_DIS_ADDR) ? ana_q :
                       (reg_addr == pmc_pkg::MODE_ADDR) ? mode_view : 8'h00;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rdata_q <= 8'h00;
      end else if (reg_rd) begin
         rdata_q <= rd_mux;
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign reg_rdata = rdata_q;
   // idle gates only the cpu enable; state is frozen, not cleared
   assign cpu_clk_en = !(in_idle || in_stop) && !seq_busy;
   assign periph_clk_en = !in_stop;
   assign sys_clk_run = !in_stop;
   assign wake_irq = wake_q;
   assign int_reset = seq_busy;
   assign fetch_addr = fetch_q;
   assign analog_dis = ana_q;
   assign mode_state = {in_stop, in_idle};
endmodule : pmc_power_mode

/* test/pmc_power_mode_props.sv */
`timescale 1ns/1ps
module pmc_power_mode_props (
   input wire logic sys_clk, reset, reg_wr, reg_rd, instr_done, wdt_en, wdt_expire,
   input wire logic mcd_en, mcd_fault, ext_reset_n, cpu_clk_en, periph_clk_en,
   input wire logic sys_clk_run, wake_irq, int_reset,
   input wire logic [7:0] reg_addr, reg_wdata, reg_rdata, irq_req, irq_en,
   input wire logic [15:0] fetch_addr,
   input wire logic [1:0] mode_state
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   // no external, watchdog or clock-detector reset source active in this cycle (osc_off not checked)
   wire logic quiet = ext_reset_n && !wdt_expire && !mcd_fault;
   AST_RD_IDLE_ZERO: assert property (reg_rd && reg_addr == 8'h87 |=> reg_rdata[1:0] == 2'b00)
      else $error("mode select bits read back nonzero");
   AST_IDLE_CLOCKS: assert property (mode_state == 2'b01 |-> !cpu_clk_en && periph_clk_en
      && sys_clk_run) else $error("idle clock gating wrong");
   AST_STOP_CLOCKS: assert property (mode_state == 2'b10 |-> !cpu_clk_en && !periph_clk_en
      && !sys_clk_run) else $error("stop clocks still running");
   AST_WAIT_INSTR: assert property (reg_wr && reg_addr == 8'h87 && reg_wdata[0] ##1 !instr_done
      |=> mode_state == 2'b00) else $error("idle before instruction end");
   AST_IRQ_WAKE: assert property (mode_state == 2'b01 && |(irq_req & irq_en) && quiet
      |=> mode_state == 2'b00 && cpu_clk_en ##[0:1] wake_irq) else $error("no irq wake");
   AST_MASKED_STAY: assert property (mode_state == 2'b01 && (irq_req & irq_en) == 8'h00 && quiet
      |=> mode_state == 2'b01) else $error("idle left without cause");
   AST_STOP_STAY: assert property (mode_state == 2'b10 && quiet |=> mode_state == 2'b10)
      else $error("stop left without reset");
   AST_RST_SEQ: assert property ($rose(int_reset) && quiet |-> int_reset [*4] ##1 !int_reset)
      else $error("reset sequence length wrong");
   AST_FETCH_VEC: assert property ($fell(int_reset) |-> fetch_addr == 16'h0000 && cpu_clk_en)
      else $error("fetch not at reset vector");
   AST_WDT_WAKE: assert property (mode_state == 2'b01 && wdt_en && wdt_expire
      |-> ##[1:2] int_reset) else $error("watchdog did not end idle");
   AST_MCD_WAKE: assert property (mode_state == 2'b10 && mcd_en && mcd_fault
      |-> ##[1:2] int_reset) else $error("clock detector did not end stop");
endmodule : pmc_power_mode_props
bind pmc_power_mode pmc_power_mode_props u_props (.*);

/* test/pmc_core_model.sv */
`timescale 1ns/1ps
module pmc_core_model (
   input wire logic sys_clk, // system clock
   input wire logic slow, // stretch instructions to eight cycles
   output logic instr_done = 1'b0 // instruction boundary
);
   logic [2:0] cnt_q = 3'h0;
   always_ff @(posedge sys_clk) begin
      cnt_q <= cnt_q + 3'h1;
      instr_done <= slow ? (cnt_q == 3'h7) : cnt_q[0];
   end
endmodule : pmc_core_model

/* test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   logic sys_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, osc_off = 1'b0;
   logic wdt_en = 1'b0, wdt_expire = 1'b0, mcd_en = 1'b0, mcd_fault = 1'b0, slow = 1'b0;
   logic ext_reset_n = 1'b1, instr_done, cpu_clk_en, periph_clk_en, sys_clk_run;
   logic wake_irq, int_reset;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, irq_req = 8'h00, irq_en = 8'h00;
   logic [7:0] reg_rdata, analog_dis, d;
   logic [15:0] fetch_addr;
   logic [1:0] mode_state, m;
   int errors = 0, tests_run = 0, cyc = 0;
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end
   always #10 sys_clk = ~sys_clk;
   pmc_core_model core (.*);
   pmc_power_mode dut (.*);
   function automatic logic [1:0] exp_mode(input logic [7:0] r, e);
      return (|(r & e)) ? 2'b00 : 2'b01;
   endfunction : exp_mode
   task automatic final_report;
      if (errors == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : tick
   task automatic acc(input logic w, input logic [7:0] a, v);
      @(posedge sys_clk);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
      if (!w) `CHK("reg_rdata", v, reg_rdata)
   endtask : acc
   task automatic enter(input logic [7:0] v);
      acc(1'b1, 8'h87, v);
      tick(10);
   endtask : enter
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc > 3000) begin
         errors++;
         final_report();
      end
   end
   initial begin
      void'($urandom(13219));
      tick(6);
      reset <= 1'b0;
      tick(6);
      #1 `CHK("fetch_addr", 16'h0000, fetch_addr)
      acc(1'b0, 8'h87, 8'h00);
      acc(1'b1, 8'h87, 8'hfc);
      acc(1'b0, 8'h87, 8'hfc);
      d = 8'($urandom);
      acc(1'b1, 8'h88, d);
      acc(1'b0, 8'hf0, 8'h00);
      #1 `CHK("analog_dis", d, analog_dis)
      for (int i = 0; i < 8; i++) begin
         enter(8'h01);
         irq_req <= i ? 8'($urandom) : 8'h80;
         irq_en <= i ? 8'($urandom) : 8'h7f;
         slow <= i[0];
         #1 `CHK("idle", 2'b01, mode_state)
         m = exp_mode(irq_req, irq_en);
         tick(3);
         irq_req <= 8'h01;
         irq_en <= 8'h01;
         #1 `CHK("wake", m, mode_state)
         tick(3);
         irq_req <= 8'h00;
         #1 `CHK("resume", 2'b00, mode_state)
      end
      enter(8'h02);
      irq_req <= 8'hff;
      irq_en <= 8'hff;
      #1 `CHK("stop", 2'b10, mode_state)
      tick(4);
      irq_req <= 8'h00;
      ext_reset_n <= 1'b0;
      #1 `CHK("stop_irq", 2'b10, mode_state)
      tick(8);
      ext_reset_n <= 1'b1;
      tick(14);
      #1 `CHK("ext_wake", 2'b00, mode_state)
      `CHK("fetch_vec", 16'h0000, fetch_addr)
      for (int k = 0; k < 2; k++) begin
         mcd_en <= 1'b1;
         wdt_en <= 1'b1;
         enter(k ? 8'h02 : 8'h01);
         wdt_expire <= !k[0];
         mcd_fault <= k[0];
         #1 `CHK("fault_mode", (k ? 2'b10 : 2'b01), mode_state)
         tick(1);
         wdt_expire <= 1'b0;
         mcd_fault <= 1'b0;
         tick(12);
         #1 `CHK("fault_wake", 2'b00, mode_state)
      end
      enter(8'h01);
      acc(1'b0, 8'h89, 8'h01);
      irq_req <= 8'h01;
      tick(4);
      irq_req <= 8'h00;
      osc_off <= 1'b1;
      tick(1);
      osc_off <= 1'b0;
      #1 `CHK("osc_rst", 1'b1, int_reset)
      final_report();
   end
endmodule : tb_top
